// [core/mpm_phase_manager.sv]
// Phase count, shedding, three-level phase outputs and frequency slew
//
// Operation
// - Active phase count N comes from lowest phase pin strapped high.
// - Active phases fire in order 1 to N, evenly spaced over the period.
// - Phase reduction takes effect from the next switching cycle.
// - Low-power field plus shed pin pick the inductor arrangement.
// - Codes 0..3: uncoupled min1, uncoupled min2, coupled min1, min2.
// - Low power runs phase 1 alone or with phase 2 or 3.
// - Transient phase-add trigger restores all phases at once.
// - Two coupled phases run half a period apart.
// - Dropped coupled phase drives low-side on while phase 1 is high.
// - When operational, mid level in soft start, shed phases, faults.
// - Outputs are low, mid or high; mid level selectable 3.3V or 5V.
// - Diode emulation should be off in device and stage if unmatched.
// - Switching frequency programmable 120kHz to 2.025MHz.
// - 15kHz steps; setting approached one step every 20us.
// - Current sense enabled only for active channels.
`timescale 1ns/10ps
module mpm_phase_manager (
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    input  wire logic [5:0]             phase_in,
    output logic [5:0]                  phase_out_oe,
    output mpm_pkg::mpm_lvl_t [5:0]     phase_lvl,
    input  wire mpm_pkg::mpm_ctl_in_t   ctl_pins,
    input  wire logic [7:0]             pwm_on_cycles,
    input  wire mpm_pkg::mpm_mgmt_t     mgmt,
    output logic [7:0]                  mgmt_rdata,
    output logic                        mid_level_5v,
    output logic                        diode_emul_en,
    output logic [5:0]                  current_sense_en,
    output logic [2:0]                  phase_count
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] strap_count(input logic [5:0] s);
        logic [2:0] n;
        n = 3'd6;
        for (int i = 5; i >= 0; i--) begin
            if (s[i]) begin
                n = 3'(i);
            end
        end
        return n;
    endfunction

    function automatic logic [5:0] low_mask(input logic [2:0] n);
        return 6'((7'h01 << n) - 7'h01);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [13:0] sync1_ff, sync2_ff;
    mpm_pkg::mpm_ctl_in_t pin_s;
    logic [5:0] strap_s;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync1_ff <= 14'h0000;
            sync2_ff <= 14'h0000;
        end else begin
            sync1_ff <= {phase_in, ctl_pins};
            sync2_ff <= sync1_ff;
        end
    end
    assign strap_s = sync2_ff[13:8];
    assign pin_s   = mpm_pkg::mpm_ctl_in_t'(sync2_ff[7:0]);

    ////////////////////////////////////////////////////////////////////////
    // Registers and strap capture
    logic [1:0] lpc_ff, nxt_lpc;
    logic [6:0] freq_ff, nxt_freq;
    logic [1:0] ctrl_ff, nxt_ctrl;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [1:0] strap_cnt_ff, nxt_strap_cnt;
    logic       strap_done_ff, nxt_strap_done;
    logic [2:0] n_ff, nxt_n;
    logic       shed_ff, nxt_shed;
    logic [6:0] cur_ff, nxt_cur;
    mpm_pkg::mpm_lp_mode_t mode;

    assign mode = mpm_pkg::mpm_lp_mode_t'(lpc_ff);

    always_comb begin
        nxt_lpc        = lpc_ff;
        nxt_freq       = freq_ff;
        nxt_ctrl       = ctrl_ff;
        nxt_strap_cnt  = strap_cnt_ff;
        nxt_strap_done = strap_done_ff;
        nxt_n          = n_ff;
        if (mgmt.wr) begin
            unique case (mgmt.addr)
                mpm_pkg::LPC_OFS:  nxt_lpc = mgmt.wdata[1:0];
                mpm_pkg::FREQ_OFS: begin
                    nxt_freq = (mgmt.wdata[6:0] > mpm_pkg::FREQ_MAX) ?
                               mpm_pkg::FREQ_MAX : mgmt.wdata[6:0];
                end
                mpm_pkg::CTRL_OFS: nxt_ctrl = mgmt.wdata[1:0];
                default:           nxt_lpc = lpc_ff;
            endcase
        end
        if (!strap_done_ff) begin
            if (strap_cnt_ff == mpm_pkg::STRAP_WAIT) begin
                nxt_strap_done = 1'b1;
                nxt_n          = strap_count(strap_s);
            end else begin
                nxt_strap_cnt = strap_cnt_ff + 2'h1;
            end
        end
        unique case (mgmt.addr)
            mpm_pkg::LPC_OFS:  nxt_rdata = {6'h00, lpc_ff};
            mpm_pkg::FREQ_OFS: nxt_rdata = {1'b0, freq_ff};
            mpm_pkg::CTRL_OFS: nxt_rdata = {6'h00, ctrl_ff};
            mpm_pkg::STAT_OFS: nxt_rdata = {4'h0, shed_ff, n_ff};
            mpm_pkg::FNOW_OFS: nxt_rdata = {1'b0, cur_ff};
            default:           nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lpc_ff        <= mpm_pkg::LPC_RST;
            freq_ff       <= mpm_pkg::FREQ_RST;
            ctrl_ff       <= 2'h0;
            rdata_ff      <= 8'h00;
            strap_cnt_ff  <= 2'h0;
            strap_done_ff <= 1'b0;
            n_ff          <= 3'h0;
        end else begin
            lpc_ff        <= nxt_lpc;
            freq_ff       <= nxt_freq;
            ctrl_ff       <= nxt_ctrl;
            rdata_ff      <= nxt_rdata;
            strap_cnt_ff  <= nxt_strap_cnt;
            strap_done_ff <= nxt_strap_done;
            n_ff          <= nxt_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frequency slew, period counter and shedding state
    logic [9:0]  tick_cnt_ff, nxt_tick_cnt;
    logic [7:0]  cnt_ff, nxt_cnt;
    logic        tick, wrap, shed_req;
    logic [10:0] freq_khz;
    logic [7:0]  period, spacing;
    logic [2:0]  active;

    assign tick     = (tick_cnt_ff == mpm_pkg::STEP_CYC - 10'd1);
    assign freq_khz = 11'(mpm_pkg::FREQ_MIN_KHZ)
                    + 11'(cur_ff) * 11'(mpm_pkg::FREQ_STP_KHZ);
    assign period   = 8'(15'(mpm_pkg::CLK_KHZ) / 15'(freq_khz));
    assign spacing  = period / 8'(active);
    assign wrap     = (cnt_ff >= period - 8'd1);
    assign shed_req = pin_s.shed_req && !pin_s.transient_phase_add;

    always_comb begin
        nxt_tick_cnt = tick ? 10'h000 : tick_cnt_ff + 10'h001;
        nxt_cur      = cur_ff;
        if (tick && cur_ff < freq_ff) begin
            nxt_cur = cur_ff + 7'h01;
        end else if (tick && cur_ff > freq_ff) begin
            nxt_cur = cur_ff - 7'h01;
        end
        nxt_cnt = wrap ? 8'h00 : cnt_ff + 8'h01;
        if (!shed_req) begin
            nxt_shed = 1'b0;
        end else if (wrap) begin
            nxt_shed = 1'b1;
        end else begin
            nxt_shed = shed_ff;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tick_cnt_ff <= 10'h000;
            cur_ff      <= mpm_pkg::FREQ_RST;
            cnt_ff      <= 8'h00;
            shed_ff     <= 1'b0;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
            cur_ff      <= nxt_cur;
            cnt_ff      <= nxt_cnt;
            shed_ff     <= nxt_shed;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase arrangement and output levels
    logic [2:0]  min_cnt, partner;
    logic        coupled, low_pwr, oper, hold_mid, drop_cpl;
    logic [5:0]  run_mask;
    mpm_pkg::mpm_lvl_t [5:0] lvl_ff, nxt_lvl;
    logic        drop_cpl_ff, nxt_drop_cpl;

    always_comb begin
        coupled = (mode == mpm_pkg::MPM_COUPLED_MIN_ONE) ||
                  (mode == mpm_pkg::MPM_COUPLED_MIN_TWO);
        min_cnt = ((mode == mpm_pkg::MPM_UNCOUPLED_MIN_ONE) ||
                   (mode == mpm_pkg::MPM_COUPLED_MIN_ONE)) ? 3'd1 : 3'd2;
        partner = (coupled || n_ff < 3'd4) ? 3'd1 : 3'd2;
        low_pwr = shed_ff && (n_ff > min_cnt);
        if (low_pwr) begin
            active   = min_cnt;
            run_mask = (min_cnt == 3'd1) ? 6'h01 :
                       (6'h01 | (6'h01 << partner));
        end else begin
            active   = (n_ff == 3'd0) ? 3'd1 : n_ff;
            run_mask = low_mask(n_ff);
        end
        drop_cpl = low_pwr && coupled && (min_cnt == 3'd1);
        oper     = strap_done_ff && (n_ff != 3'd0) &&
                   pin_s.thermal_enable_input &&
                   pin_s.power_enable_input && pin_s.vid_valid;
        hold_mid = pin_s.soft_start || pin_s.fault_oc || pin_s.fault_ov;
        nxt_drop_cpl = drop_cpl && oper && !hold_mid;
        for (int i = 0; i < mpm_pkg::NPH; i++) begin
            logic [7:0] start, ofs, slot;
            slot  = low_pwr ? ((i == 0) ? 8'd0 : 8'd1) : 8'(i);
            start = 8'(slot * spacing);
            ofs   = (cnt_ff >= start) ? cnt_ff - start
                                      : 8'(cnt_ff + period - start);
            if (!oper) begin
                nxt_lvl[i] = mpm_pkg::MPM_LVL_LOW;
            end else if (hold_mid) begin
                nxt_lvl[i] = mpm_pkg::MPM_LVL_MID;
            end else if (run_mask[i]) begin
                nxt_lvl[i] = (ofs < pwm_on_cycles) ? mpm_pkg::MPM_LVL_HIGH
                                                   : mpm_pkg::MPM_LVL_LOW;
            end else if (drop_cpl && i == 1) begin
                nxt_lvl[i] = (nxt_lvl[0] == mpm_pkg::MPM_LVL_HIGH) ?
                             mpm_pkg::MPM_LVL_LOW :
                             mpm_pkg::MPM_LVL_MID;
            end else begin
                nxt_lvl[i] = mpm_pkg::MPM_LVL_MID;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lvl_ff      <= '{default: mpm_pkg::MPM_LVL_LOW};
            drop_cpl_ff <= 1'b0;
        end else begin
            lvl_ff      <= nxt_lvl;
            drop_cpl_ff <= nxt_drop_cpl;
        end
    end

    assign phase_lvl        = lvl_ff;
    assign phase_out_oe     = strap_done_ff ? low_mask(n_ff) : 6'h00;
    assign current_sense_en = strap_done_ff ? low_mask(n_ff) : 6'h00;
    assign phase_count      = n_ff;
    assign mid_level_5v     = ctrl_ff[mpm_pkg::CTRL_MID5_B];
    assign diode_emul_en    = ctrl_ff[mpm_pkg::CTRL_DIODE_B];
    assign mgmt_rdata       = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_off_no_drive;
        @(posedge ref_clk) disable iff (reset)
        (strap_done_ff && n_ff == 3'd0) |-> (phase_out_oe == 6'h00);
    endproperty
    a_off_no_drive: assert property (p_off_no_drive)
        else $error("Phases driven while regulator strapped off");

    property p_shed_on_wrap;
        @(posedge ref_clk) disable iff (reset)
        $rose(shed_ff) |-> $past(wrap);
    endproperty
    a_shed_on_wrap: assert property (p_shed_on_wrap)
        else $error("Shedding began inside a switching cycle");

    property p_transient_restore;
        @(posedge ref_clk) disable iff (reset)
        pin_s.transient_phase_add |=> !shed_ff;
    endproperty
    a_transient_restore: assert property (p_transient_restore)
        else $error("Transient trigger did not restore phases");

    property p_slew_tick;
        @(posedge ref_clk) disable iff (reset)
        (cur_ff != $past(cur_ff)) |-> ($past(tick) &&
            (cur_ff == $past(cur_ff) + 7'h01 ||
             cur_ff == $past(cur_ff) - 7'h01));
    endproperty
    a_slew_tick: assert property (p_slew_tick)
        else $error("Frequency code moved off step timing");

    property p_freq_range;
        @(posedge ref_clk) disable iff (reset)
        (mgmt.wr && mgmt.addr == mpm_pkg::FREQ_OFS)
            |=> (freq_ff == $past(mgmt.wdata[6:0]));
    endproperty
    a_freq_range: assert property (p_freq_range)
        else $error("Frequency code write did not land");

    property p_fault_mid;
        @(posedge ref_clk) disable iff (reset)
        (oper && hold_mid) |=> (phase_lvl[0] == mpm_pkg::MPM_LVL_MID);
    endproperty
    a_fault_mid: assert property (p_fault_mid)
        else $error("Phase not at mid level during hold");

    property p_coupled_lowside;
        @(posedge ref_clk) disable iff (reset)
        (drop_cpl_ff && phase_lvl[0] == mpm_pkg::MPM_LVL_HIGH)
            |-> (phase_lvl[1] == mpm_pkg::MPM_LVL_LOW);
    endproperty
    a_coupled_lowside: assert property (p_coupled_lowside)
        else $error("Dropped coupled phase not low with phase 1 high");

    property p_coupled_half;
        @(posedge ref_clk) disable iff (reset)
        (low_pwr && mode == mpm_pkg::MPM_COUPLED_MIN_TWO)
            |-> (spacing == period / 8'd2 && run_mask == 6'h03);
    endproperty
    a_coupled_half: assert property (p_coupled_half)
        else $error("Coupled pair not half a period apart");

    property p_sense_match;
        @(posedge ref_clk) disable iff (reset)
        strap_done_ff |-> (current_sense_en == phase_out_oe &&
            $countones(current_sense_en) == int'(phase_count));
    endproperty
    a_sense_match: assert property (p_sense_match)
        else $error("Sense enables differ from active phases");

    property p_counter_bound;
        @(posedge ref_clk) disable iff (reset)
        wrap |=> (cnt_ff == 8'h00);
    endproperty
    a_counter_bound: assert property (p_counter_bound)
        else $error("Period counter failed to restart");
endmodule

// [inc/mpm_pkg.sv]
// Shared constants and types of the multiphase phase manager
package mpm_pkg;
    localparam int          NPH          = 6;
    localparam logic [7:0]  LPC_OFS      = 8'hd2;
    localparam logic [7:0]  FREQ_OFS     = 8'hd3;
    localparam logic [7:0]  CTRL_OFS     = 8'hd4;
    localparam logic [7:0]  STAT_OFS     = 8'hd5;
    localparam logic [7:0]  FNOW_OFS     = 8'hd6;
    localparam logic [1:0]  LPC_RST      = 2'h0;
    localparam logic [6:0]  FREQ_RST     = 7'h00;
    localparam logic [6:0]  FREQ_MAX     = 7'h7f;
    localparam int          CTRL_MID5_B  = 0;
    localparam int          CTRL_DIODE_B = 1;
    localparam int          STAT_SHED_B  = 3;
    localparam int          FREQ_MIN_KHZ = 120;
    localparam int          FREQ_STP_KHZ = 15;
    localparam int          CLK_KHZ      = 25000;
    localparam int          CLK_NS       = 40;
    localparam int          STEP_NS      = 20000;
    localparam logic [9:0]  STEP_CYC     = 10'(STEP_NS / CLK_NS);
    localparam logic [1:0]  STRAP_WAIT   = 2'h3;

    typedef enum logic [1:0] {
        MPM_UNCOUPLED_MIN_ONE = 2'h0,
        MPM_UNCOUPLED_MIN_TWO = 2'h1,
        MPM_COUPLED_MIN_ONE   = 2'h2,
        MPM_COUPLED_MIN_TWO   = 2'h3
    } mpm_lp_mode_t;

    typedef enum logic [1:0] {
        MPM_LVL_LOW  = 2'h0,
        MPM_LVL_MID  = 2'h1,
        MPM_LVL_HIGH = 2'h2
    } mpm_lvl_t;

    typedef struct packed {
        logic soft_start;
        logic fault_oc;
        logic fault_ov;
        logic shed_req;
        logic transient_phase_add;
        logic thermal_enable_input;
        logic power_enable_input;
        logic vid_valid;
    } mpm_ctl_in_t;

    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } mpm_mgmt_t;
endpackage

// [dv/mpm_stage_model.sv]
// Power stage model sitting on the phase pins
`timescale 1ns/10ps
module mpm_stage_model (
    input  wire logic                    diode_emul_en,
    input  wire logic [5:0]              strap,
    input  wire logic [5:0]              phase_out_oe,
    input  wire mpm_pkg::mpm_lvl_t [5:0] phase_lvl,
    output logic [5:0]                   phase_in,
    output logic [5:0]                   low_side_gate
);
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            // Strap to supply wins, a driven high reads high
            phase_in[i] = strap[i] | (phase_out_oe[i]
                & (phase_lvl[i] == mpm_pkg::MPM_LVL_HIGH));
            // Low-side on only for low level, no diode emulation
            low_side_gate[i] = phase_out_oe[i] & ~diode_emul_en
                & (phase_lvl[i] == mpm_pkg::MPM_LVL_LOW);
        end
    end
endmodule

// [dv/tb_multiphase_phase_manager.sv]
// Self-checking bench of the multiphase phase manager
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    err_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb_multiphase_phase_manager;
    localparam int PER  = mpm_pkg::CLK_KHZ / mpm_pkg::FREQ_MIN_KHZ;
    localparam int STEP = mpm_pkg::STEP_NS / mpm_pkg::CLK_NS;
    localparam mpm_pkg::mpm_lvl_t LO  = mpm_pkg::MPM_LVL_LOW;
    localparam mpm_pkg::mpm_lvl_t MID = mpm_pkg::MPM_LVL_MID;
    localparam mpm_pkg::mpm_lvl_t HI  = mpm_pkg::MPM_LVL_HIGH;
    logic                    ref_clk = 1'b0;
    logic                    reset = 1'b1;
    logic [5:0]              strap = 6'h10;
    logic [5:0]              phase_in;
    logic [5:0]              phase_out_oe;
    mpm_pkg::mpm_lvl_t [5:0] phase_lvl;
    mpm_pkg::mpm_ctl_in_t    ctl_pins = 8'h07;
    logic [7:0]              pwm_on_cycles = 8'h08;
    mpm_pkg::mpm_mgmt_t      mgmt = '0;
    logic [7:0]              mgmt_rdata;
    logic                    mid_level_5v;
    logic                    diode_emul_en;
    logic [5:0]              current_sense_en;
    logic [5:0]              low_side_gate;
    logic [2:0]              phase_count;
    logic [7:0]              rd;
    int                      err_count = 0;
    int                      samples_checked = 0;
    int                      t [6];
    int                      bad;

    mpm_phase_manager DUT (.ref_clk(ref_clk), .reset(reset),
        .phase_in(phase_in), .phase_out_oe(phase_out_oe),
        .phase_lvl(phase_lvl), .ctl_pins(ctl_pins),
        .pwm_on_cycles(pwm_on_cycles), .mgmt(mgmt),
        .mgmt_rdata(mgmt_rdata), .mid_level_5v(mid_level_5v),
        .diode_emul_en(diode_emul_en),
        .current_sense_en(current_sense_en), .phase_count(phase_count));
    mpm_stage_model STAGE (.diode_emul_en(diode_emul_en), .strap(strap),
        .phase_out_oe(phase_out_oe), .phase_lvl(phase_lvl),
        .phase_in(phase_in), .low_side_gate(low_side_gate));

    always #20 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Counts: %0d mismatches, %0d comparisons", err_count,
            samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        mgmt <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk);
        mgmt.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a);
        @(posedge ref_clk);
        mgmt.addr <= a;
        @(posedge ref_clk);
        #1 rd = mgmt_rdata;
    endtask

    task automatic do_reset(input logic [5:0] s);
        @(posedge ref_clk);
        strap <= s;
        reset <= 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 `CHK(phase_out_oe, 6'h00)
        @(posedge ref_clk);
        reset <= 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask

    task automatic lvl_chk(input logic [5:0] m, input mpm_pkg::mpm_lvl_t v);
        for (int i = 0; i < 6; i++) begin
            if (m[i]) `CHK(phase_lvl[i], v)
        end
    endtask

    task automatic wait_shed(input logic v);
        for (int k = 0; k < 300; k++) begin
            reg_rd(mpm_pkg::STAT_OFS);
            if (rd[mpm_pkg::STAT_SHED_B] === v) return;
        end
        err_count++;
        stop_test();
    endtask

    // First rising edge of each phase, coupled low-side violations
    task automatic scan(input int cyc);
        mpm_pkg::mpm_lvl_t prev [6];
        bad = 0;
        for (int i = 0; i < 6; i++) t[i] = -1;
        for (int c = 0; c < cyc; c++) begin
            @(posedge ref_clk);
            #1;
            for (int i = 0; i < 6; i++) begin
                if (c > 0 && t[i] < 0 && phase_lvl[i] == HI && prev[i] != HI)
                    t[i] = c;
                prev[i] = phase_lvl[i];
            end
            if (phase_lvl[0] == HI && (phase_lvl[1] !== LO ||
                low_side_gate[1] !== 1'b1)) bad++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_strap();
        logic [5:0] s [4] = '{6'h01, 6'h04, 6'h00, 6'h10};
        logic [2:0] n [4] = '{3'h0, 3'h2, 3'h6, 3'h4};
        logic [5:0] k [4] = '{6'h00, 6'h03, 6'h3f, 6'h0f};
        for (int i = 0; i < 4; i++) begin
            do_reset(s[i]);
            `CHK(phase_count, n[i])
            `CHK(current_sense_en, k[i])
            `CHK(phase_out_oe, k[i])
            if (n[i] == 3'h0) lvl_chk(6'h3f, LO);
        end
        $display("Test strap done");
    endtask

    task automatic test_regs();
        reg_rd(mpm_pkg::LPC_OFS);
        `CHK(rd, 8'h00)
        reg_rd(mpm_pkg::FREQ_OFS);
        `CHK(rd, 8'h00)
        reg_wr(mpm_pkg::CTRL_OFS, 8'hff);
        reg_rd(mpm_pkg::CTRL_OFS);
        `CHK(rd, 8'h03)
        `CHK(mid_level_5v, 1'b1)
        `CHK(diode_emul_en, 1'b1)
        reg_wr(mpm_pkg::CTRL_OFS, 8'h00);
        reg_rd(mpm_pkg::LPC_OFS);
        `CHK(mid_level_5v, 1'b0)
        reg_wr(mpm_pkg::LPC_OFS, 8'hff);
        reg_rd(mpm_pkg::LPC_OFS);
        `CHK(rd, 8'h03)
        reg_wr(mpm_pkg::STAT_OFS, 8'hff);
        reg_rd(mpm_pkg::STAT_OFS);
        `CHK(rd, 8'h04)
        reg_wr(8'h10, 8'hff);
        reg_rd(8'h10);
        `CHK(rd, 8'h00)
        reg_wr(mpm_pkg::LPC_OFS, 8'h00);
        $display("Test regs done");
    endtask

    task automatic test_gate();
        logic [7:0] v [6] = '{8'h87, 8'h47, 8'h27, 8'h03, 8'h05, 8'h06};
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            ctl_pins <= v[i];
            repeat (6) @(posedge ref_clk);
            #1 lvl_chk(6'h0f, (i < 3) ? MID : LO);
            @(posedge ref_clk);
            ctl_pins <= 8'h07;
            repeat (6) @(posedge ref_clk);
        end
        $display("Test gate done");
    endtask

    task automatic test_order();
        scan(2 * PER);
        for (int i = 1; i < 4; i++) begin
            `CHK((t[i] - t[0] + PER) % PER, i * (PER / 4))
        end
        $display("Test order done");
    endtask

    task automatic test_shed();
        logic [3:0] run [4] = '{4'h1, 4'h5, 4'h1, 4'h3};
        for (int m = 0; m < 4; m++) begin
            reg_wr(mpm_pkg::LPC_OFS, 8'(m));
            @(posedge ref_clk);
            ctl_pins.shed_req <= 1'b1;
            wait_shed(1'b1);
            scan(2 * PER);
            for (int i = 0; i < 4; i++) begin
                `CHK(t[i] >= 0, run[m][i])
            end
            if (m == 2) `CHK(bad, 0)
            if (m == 3) `CHK((t[1] - t[0] + PER) % PER, PER / 2)
            if (m != 2) lvl_chk({2'h0, ~run[m]}, MID);
            @(posedge ref_clk);
            ctl_pins.shed_req <= 1'b0;
            wait_shed(1'b0);
        end
        $display("Test shed done");
    endtask

    task automatic test_apa();
        reg_wr(mpm_pkg::LPC_OFS, 8'h00);
        @(posedge ref_clk);
        ctl_pins.shed_req <= 1'b1;
        wait_shed(1'b1);
        @(posedge ref_clk);
        ctl_pins.transient_phase_add <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reg_rd(mpm_pkg::STAT_OFS);
        `CHK(rd[mpm_pkg::STAT_SHED_B], 1'b0)
        for (int i = 1; i < 4; i++) `CHK(phase_lvl[i] != MID, 1'b1)
        @(posedge ref_clk);
        ctl_pins <= 8'h07;
        wait_shed(1'b0);
        $display("Test transient done");
    endtask

    task automatic test_freq();
        int t1 = -1;
        int t2 = -1;
        logic [7:0] last;
        reg_wr(mpm_pkg::FREQ_OFS, 8'h04);
        @(posedge ref_clk);
        mgmt.addr <= mpm_pkg::FNOW_OFS;
        @(posedge ref_clk);
        #1 last = mgmt_rdata;
        for (int c = 0; c < 5 * STEP; c++) begin
            @(posedge ref_clk);
            #1;
            if (mgmt_rdata !== last) begin
                if (t1 < 0) t1 = c;
                else if (t2 < 0) t2 = c;
                last = mgmt_rdata;
            end
        end
        `CHK(last, 8'h04)
        `CHK(t2 - t1, STEP)
        reg_wr(mpm_pkg::FREQ_OFS, 8'hff);
        reg_rd(mpm_pkg::FREQ_OFS);
        `CHK(rd, 8'h7f)
        reg_wr(mpm_pkg::FREQ_OFS, 8'h00);
        $display("Test frequency done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        test_strap();
        test_regs();
        test_gate();
        test_order();
        test_shed();
        test_apa();
        test_freq();
        stop_test();
    end

    initial begin
        repeat (100000) @(posedge ref_clk);
        err_count++;
        stop_test();
    end
endmodule
